// ### hdl/cod_clock_output_divider.sv
// Notes on behaviour
// - Enable set with factor zero drives the undivided CPU clock on the pin.
// - Factor writes are taken only while both extension-bus enables are set.
// - With the output enable clear the pin stays low whatever the factor.
// - The divider register sits in the miscellaneous window, apart from others.
// - Idle, power-down and stand-by stop the CPU clock as per mode.
module cod_clock_output_divider
    import cod_pkg::*;
#(
    parameter int unsigned DIV_W = COD_DIV_W
)(
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [COD_ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [COD_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    // AXI4-Lite write response
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [COD_ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [COD_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    // Wake-up from idle or power-down
    input  wire logic                  wake_request,
    // Clock pin
    output logic                       divided_clock_output,
    // Clock tree run flags
    output logic                       cpu_clock_run,
    output logic                       periph_clock_run,
    output logic                       rtc_run,
    output logic                       main_osc_run,
    output logic                       osc32_run
);

    typedef struct packed {
        logic                  awready;
        logic                  wready;
        logic                  aw_have;
        logic [COD_ADDR_W-1:0] aw_addr;
        logic                  w_have;
        logic [COD_DATA_W-1:0] w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [COD_DATA_W-1:0] rdata;
        logic [1:0]            rresp;
        logic                  clock_output_enable;
        logic                  extension_peripheral_enable;
        logic                  misc_extension_bus_enable;
        logic [DIV_W-1:0]      clock_output_divider;
        cod_mode_t             mode;
        logic                  rtc_on;
        logic                  rtc32;
        cod_run_t              run;
    } cod_state_t;

    cod_state_t st;
    cod_state_t nxt;
    logic       pin_level;
    logic       div_enable;
    logic       wr_commit;
    logic       div_gate;

    // Both halves of a write are held until the response has been taken
    assign wr_commit = st.aw_have && st.w_have && !st.bvalid;
    assign div_gate  = st.extension_peripheral_enable && st.misc_extension_bus_enable;

    // The pin stops with the CPU clock, since it is a copy of it
    assign div_enable = st.clock_output_enable && st.run.cpu;

    // Bus slave, register file and mode control
    always_comb
    begin
        nxt = st;
        if (s_axi_awvalid && st.awready)
        begin
            nxt.aw_have = 1'b1;
            nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            nxt.w_have = 1'b1;
            nxt.w_data = s_axi_wdata;
            nxt.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready)
            nxt.bvalid = 1'b0;
        if (wr_commit)
        begin
            nxt.aw_have = 1'b0;
            nxt.w_have  = 1'b0;
            nxt.bvalid  = 1'b1;
            nxt.bresp   = COD_RESP_OKAY;
            // All fields live in byte lane 0
            unique case (st.aw_addr)
                COD_OFF_SYSCONF:
                begin
                    if (st.w_strb[0])
                    begin
                        nxt.clock_output_enable         = st.w_data[COD_SYS_OUTEN_BIT];
                        nxt.extension_peripheral_enable = st.w_data[COD_SYS_EXTEN_BIT];
                    end
                end
                COD_OFF_EXTCONF:
                begin
                    if (st.w_strb[0])
                        nxt.misc_extension_bus_enable = st.w_data[COD_XPC_MISC_BIT];
                end
                COD_OFF_PWRCTL:
                begin
                    if (st.w_strb[0])
                    begin
                        nxt.mode   = cod_mode_t'(st.w_data[COD_PWR_MODE_LSB +: COD_PWR_MODE_W]);
                        nxt.rtc_on = st.w_data[COD_PWR_RTC_BIT];
                        nxt.rtc32  = st.w_data[COD_PWR_RTC32_BIT];
                    end
                end
                COD_OFF_CLKDIV:
                begin
                    // Locked writes still answer OKAY; software reads back to check
                    if (st.w_strb[0] && div_gate)
                        nxt.clock_output_divider = st.w_data[DIV_W-1:0];
                end
                COD_OFF_STATUS:
                begin
                    nxt.bresp = COD_RESP_OKAY;
                end
                default:
                begin
                    nxt.bresp = COD_RESP_SLVERR;
                end
            endcase
        end

        // Wake wins over a same-cycle mode write; stand-by ignores wake and is left by reset or a PWRCTL write
        if (wake_request && ((nxt.mode == COD_IDLE) || (nxt.mode == COD_PDOWN)))
            nxt.mode = COD_RUN;

        // Clock tree follows the mode one cycle later
        nxt.run = cod_run_flags(st.mode, st.rtc_on, st.rtc32);

        // Read channel
        if (st.rvalid && s_axi_rready)
            nxt.rvalid = 1'b0;
        if (s_axi_arvalid && st.arready)
        begin
            nxt.rvalid = 1'b1;
            nxt.rresp  = COD_RESP_OKAY;
            nxt.rdata  = '0;
            unique case (s_axi_araddr)
                COD_OFF_SYSCONF:
                begin
                    nxt.rdata[COD_SYS_OUTEN_BIT] = st.clock_output_enable;
                    nxt.rdata[COD_SYS_EXTEN_BIT] = st.extension_peripheral_enable;
                end
                COD_OFF_EXTCONF:
                    nxt.rdata[COD_XPC_MISC_BIT] = st.misc_extension_bus_enable;
                COD_OFF_PWRCTL:
                begin
                    nxt.rdata[COD_PWR_MODE_LSB +: COD_PWR_MODE_W] = st.mode;
                    nxt.rdata[COD_PWR_RTC_BIT]                    = st.rtc_on;
                    nxt.rdata[COD_PWR_RTC32_BIT]                  = st.rtc32;
                end
                COD_OFF_STATUS:
                begin
                    nxt.rdata[COD_STAT_RUN_LSB +: $bits(cod_run_t)] = st.run;
                    nxt.rdata[COD_STAT_PIN_BIT]                     = pin_level;
                end
                COD_OFF_CLKDIV:
                    nxt.rdata[DIV_W-1:0] = st.clock_output_divider;
                default:
                    nxt.rresp = COD_RESP_SLVERR;
            endcase
        end

        // Ready flags are registered; one write and one read at a time
        nxt.awready = !nxt.aw_have && !nxt.bvalid;
        nxt.wready  = !nxt.w_have && !nxt.bvalid;
        nxt.arready = !nxt.rvalid;
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= nxt;
    end

    // Pin generator
    cod_divider #(
        .DIV_W   (DIV_W)
    ) u_divider (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (div_enable),
        .factor  (st.clock_output_divider),
        .clk_out (pin_level)
    );

    // Outputs, all straight from flip-flops
    assign s_axi_awready        = st.awready;
    assign s_axi_wready         = st.wready;
    assign s_axi_bvalid         = st.bvalid;
    assign s_axi_bresp          = st.bresp;
    assign s_axi_arready        = st.arready;
    assign s_axi_rvalid         = st.rvalid;
    assign s_axi_rdata          = st.rdata;
    assign s_axi_rresp          = st.rresp;
    assign divided_clock_output = pin_level;
    assign cpu_clock_run        = st.run.cpu;
    assign periph_clock_run     = st.run.periph;
    assign rtc_run              = st.run.rtc;
    assign main_osc_run         = st.run.main_osc;
    assign osc32_run            = st.run.osc32;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_div_wr;
        wr_commit && (st.aw_addr == COD_OFF_CLKDIV) && st.w_strb[0];
    endsequence

    sequence s_div_rd;
        s_axi_arvalid && st.arready && (s_axi_araddr == COD_OFF_CLKDIV);
    endsequence

    a_div_wr_locked: assert property (
        (s_div_wr and (!div_gate)) |=> (st.clock_output_divider == $past(st.clock_output_divider)))
        else $error("divider changed while extension enables were clear");

    a_div_wr_taken: assert property (
        (s_div_wr and div_gate) |=> (st.clock_output_divider == DIV_W'($past(st.w_data))))
        else $error("divider write was not taken");

    a_misc_rd_data: assert property (
        s_div_rd |=> (st.rvalid && (st.rdata[DIV_W-1:0] == $past(st.clock_output_divider))))
        else $error("divider readback wrong in miscellaneous window");

    a_pin_off_low: assert property (
        (!st.clock_output_enable) |=> (!divided_clock_output))
        else $error("clock pin active while output disabled");

    // A new factor only lands at a toggle, so the check starts after one toggle at factor zero
    a_undiv_toggle: assert property (
        ((st.clock_output_enable && st.run.cpu && (st.clock_output_divider == '0))[*2]
         ##0 (divided_clock_output != $past(divided_clock_output)))
        |=> (divided_clock_output != $past(divided_clock_output)))
        else $error("undivided clock not seen on pin");

    a_idle_clocks: assert property (
        (st.mode == COD_IDLE) |=> (!st.run.cpu && st.run.periph && st.run.main_osc))
        else $error("idle clock tree wrong");

    a_pdown_clocks: assert property (
        (st.mode == COD_PDOWN) |=> (!st.run.cpu && !st.run.periph))
        else $error("power-down clock tree wrong");

    a_stby_rtc_osc: assert property (
        (st.mode == COD_STBY)
        |=> (!st.run.main_osc && (st.run.rtc == ($past(st.rtc_on) && $past(st.rtc32)))))
        else $error("stand-by oscillators wrong");

endmodule : cod_clock_output_divider

// ### pkg/cod_pkg.sv
package cod_pkg;

    // Bus geometry
    localparam int unsigned COD_DATA_W = 32;
    localparam int unsigned COD_ADDR_W = 12;
    localparam int unsigned COD_DIV_W  = 8;

    // Register byte offsets; the divider sits alone in the miscellaneous window
    localparam logic [COD_ADDR_W-1:0] COD_OFF_SYSCONF   = 12'h000;
    localparam logic [COD_ADDR_W-1:0] COD_OFF_EXTCONF   = 12'h004;
    localparam logic [COD_ADDR_W-1:0] COD_OFF_PWRCTL    = 12'h008;
    localparam logic [COD_ADDR_W-1:0] COD_OFF_STATUS    = 12'h00C;
    localparam logic [COD_ADDR_W-1:0] COD_OFF_MISC_BASE = 12'h100;
    localparam logic [COD_ADDR_W-1:0] COD_OFF_CLKDIV    = COD_OFF_MISC_BASE;

    // Field positions
    localparam int unsigned COD_SYS_OUTEN_BIT  = 0;
    localparam int unsigned COD_SYS_EXTEN_BIT  = 1;
    localparam int unsigned COD_XPC_MISC_BIT   = 0;
    localparam int unsigned COD_PWR_MODE_LSB   = 0;
    localparam int unsigned COD_PWR_MODE_W     = 2;
    localparam int unsigned COD_PWR_RTC_BIT    = 2;
    localparam int unsigned COD_PWR_RTC32_BIT  = 3;
    localparam int unsigned COD_STAT_RUN_LSB   = 0;
    localparam int unsigned COD_STAT_PIN_BIT   = 5;

    // Reset value of the divider factor: undivided
    localparam logic [COD_DIV_W-1:0] COD_DIV_RST = 8'h00;

    // AXI responses
    localparam logic [1:0] COD_RESP_OKAY   = 2'h0;
    localparam logic [1:0] COD_RESP_SLVERR = 2'h2;

    // Power reduction modes
    typedef enum logic [1:0] {COD_RUN, COD_IDLE, COD_PDOWN, COD_STBY} cod_mode_t;

    // Which clocks and oscillators are running
    typedef struct packed {
        logic osc32;
        logic main_osc;
        logic rtc;
        logic periph;
        logic cpu;
    } cod_run_t;

    // Clock tree state for a mode; the real-time counter survives stand-by on 32 kHz only
    function automatic cod_run_t cod_run_flags(input cod_mode_t mode,
                                               input logic      rtc_on,
                                               input logic      rtc32);
        cod_run_t r;
        r.cpu      = (mode == COD_RUN);
        r.periph   = (mode == COD_RUN) || (mode == COD_IDLE);
        r.rtc      = rtc_on && ((mode != COD_STBY) || rtc32);
        r.osc32    = r.rtc && rtc32;
        r.main_osc = (mode == COD_RUN) || (mode == COD_IDLE)
                     || ((mode == COD_PDOWN) && r.rtc && !rtc32);
        return r;
    endfunction : cod_run_flags

endpackage : cod_pkg

// ### hdl/cod_divider.sv
module cod_divider
    import cod_pkg::*;
#(
    parameter int unsigned DIV_W = COD_DIV_W
)(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Control
    input  wire logic             enable,
    input  wire logic [DIV_W-1:0] factor,
    // Pin level
    output logic                  clk_out
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [DIV_W-1:0] cur;
        logic             level;
    } cod_div_state_t;

    cod_div_state_t st;
    cod_div_state_t nxt;

    // Half period is factor+1 cycles; while enabled a new factor is only taken at a toggle
    // so that no pulse is ever cut short by a reprogramming
    always_comb
    begin
        nxt = st;
        if (!enable)
        begin
            nxt.level = 1'b0;
            nxt.cnt   = '0;
            nxt.cur   = factor;
        end
        else if (st.cnt == st.cur)
        begin
            nxt.level = !st.level;
            nxt.cnt   = '0;
            nxt.cur   = factor;
        end
        else
        begin
            nxt.cnt = st.cnt + DIV_W'(1);
        end
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= nxt;
    end

    assign clk_out = st.level;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_div_undivided: assert property (
        (enable && $past(enable) && $past(st.cur) == '0) |-> (clk_out != $past(clk_out)))
        else $error("undivided clock did not toggle every cycle");

    a_div_edge_place: assert property (
        (enable && $past(enable) && (clk_out != $past(clk_out)))
        |-> ($past(st.cnt) == $past(st.cur)))
        else $error("output edge before the half period ran out");

endmodule : cod_divider

// ### tb/cod_tb.sv
module tb
    import cod_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Bench side of every port
    logic                  aclk, aresetn, wake_request, divided_clock_output;
    logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                  s_axi_rvalid, s_axi_rready;
    logic                  cpu_clock_run, periph_clock_run, rtc_run, main_osc_run, osc32_run;
    logic [COD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [COD_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]            s_axi_wstrb;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic [4:0]            flags;
    int                    failures, n_compared;

    // Run flags in status bit order
    assign flags = {osc32_run, main_osc_run, rtc_run, periph_clock_run, cpu_clock_run};

    cod_clock_output_divider #(.DIV_W(COD_DIV_W)) cod_clock_output_divider_i
    (
        .aclk, .aresetn,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .wake_request, .divided_clock_output,
        .cpu_clock_run, .periph_clock_run, .rtc_run, .main_osc_run, .osc32_run
    );

    // 50 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // A wait that used up its bound ends the run
    task automatic tmo(input int n);
        if (n >= 200)
        begin
            failures++;
            $display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, n, 32'h0);
            end_sim();
        end
    endtask : tmo

    // Readies are flops, so the level at the falling edge is what the next rising edge samples
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic       aw, w, b;
        logic [1:0] r;
        int         n;
        n = 0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(negedge aclk);
            aw = s_axi_awready === 1'b1;
            w  = s_axi_wready === 1'b1;
            b  = s_axi_bvalid === 1'b1;
            r  = s_axi_bresp;
            @(posedge aclk);
            if (aw)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
            if (b)
                s_axi_bready <= 1'b0;
            n++;
        end while (!b && n < 200);
        tmo(n);
        chk(r, er);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic        ar, v;
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(negedge aclk);
            ar = s_axi_arready === 1'b1;
            v  = s_axi_rvalid === 1'b1;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge aclk);
            if (ar)
                s_axi_arvalid <= 1'b0;
            if (v)
                s_axi_rready <= 1'b0;
            n++;
        end while (!v && n < 200);
        tmo(n);
        chk(d, ed);
        chk(r, er);
    endtask : rd

    // Cycles between two pin toggles, seen at falling edges
    task automatic run_len(output int len);
        logic p;
        int   n;
        n = 0;
        @(negedge aclk);
        p = divided_clock_output;
        while (divided_clock_output === p && n < 200)
        begin
            @(negedge aclk);
            n++;
        end
        tmo(n);
        p   = divided_clock_output;
        len = 0;
        while (divided_clock_output === p && len < 200)
        begin
            @(negedge aclk);
            len++;
        end
        tmo(len);
    endtask : run_len

    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask : do_reset

    // Reset values, unmapped and misaligned places, read-only status
    task automatic t_regs;
        logic [11:0] a [5] = '{COD_OFF_SYSCONF, COD_OFF_EXTCONF, COD_OFF_PWRCTL,
                               COD_OFF_CLKDIV, 12'h050};
        for (int i = 0; i < 4; i++)
            rd(a[i], 32'h0, COD_RESP_OKAY);
        rd(a[4], 32'h0, COD_RESP_SLVERR);
        rd(12'h102, 32'h0, COD_RESP_SLVERR);
        wr(COD_OFF_STATUS, 32'h3F, 4'hF, COD_RESP_OKAY);
        rd(COD_OFF_STATUS, 32'h0B, COD_RESP_OKAY);
    endtask : t_regs

    // Undivided, divided, then a factor change while the pin runs
    task automatic t_pin_div;
        int len;
        wr(COD_OFF_SYSCONF, 32'h1, 4'hF, COD_RESP_OKAY);
        run_len(len);
        chk(len, 1);
        wr(COD_OFF_SYSCONF, 32'h3, 4'hF, COD_RESP_OKAY);
        wr(COD_OFF_EXTCONF, 32'h1, 4'hF, COD_RESP_OKAY);
        wr(COD_OFF_CLKDIV, 32'h3, 4'hF, COD_RESP_OKAY);
        run_len(len);
        chk(len, 4);
        fork
            wr(COD_OFF_CLKDIV, 32'h1, 4'hF, COD_RESP_OKAY);
            repeat (4)
            begin
                run_len(len);
                chk(len == 2 || len == 4, 1);
            end
        join
        run_len(len);
        chk(len, 2);
    endtask : t_pin_div

    // Output enable clear silences the pin even with a factor held
    task automatic t_pin_off;
        wr(COD_OFF_SYSCONF, 32'h2, 4'hF, COD_RESP_OKAY);
        wr(COD_OFF_CLKDIV, 32'h5, 4'hF, COD_RESP_OKAY);
        rd(COD_OFF_CLKDIV, 32'h5, COD_RESP_OKAY);
        repeat (12)
        begin
            @(negedge aclk);
            chk(divided_clock_output, 1'b0);
        end
    endtask : t_pin_off

    // Divider writes refused unless both extension enables are set
    task automatic t_lock;
        logic [31:0] sys [3] = '{32'h0, 32'h2, 32'h0};
        logic [31:0] xpc [3] = '{32'h0, 32'h0, 32'h1};
        for (int i = 0; i < 3; i++)
        begin
            wr(COD_OFF_SYSCONF, sys[i], 4'hF, COD_RESP_OKAY);
            wr(COD_OFF_EXTCONF, xpc[i], 4'hF, COD_RESP_OKAY);
            wr(COD_OFF_CLKDIV, 32'h5, 4'hF, COD_RESP_OKAY);
            rd(COD_OFF_CLKDIV, 32'h0, COD_RESP_OKAY);
        end
        wr(COD_OFF_SYSCONF, 32'h2, 4'hF, COD_RESP_OKAY);
        wr(COD_OFF_CLKDIV, 32'h7, 4'hE, COD_RESP_OKAY);
        rd(COD_OFF_CLKDIV, 32'h0, COD_RESP_OKAY);
        wr(COD_OFF_CLKDIV, 32'h3, 4'hF, COD_RESP_OKAY);
        rd(COD_OFF_CLKDIV, 32'h3, COD_RESP_OKAY);
        wr(12'h104, 32'h1, 4'hF, COD_RESP_SLVERR);
    endtask : t_lock

    // Every reduction mode; stand-by ignores wake, so it is left through reset
    task automatic t_modes;
        logic [3:0] cfg [7] = '{4'h1, 4'hD, 4'h2, 4'h6, 4'hE, 4'h3, 4'hF};
        logic [4:0] exp [7] = '{5'h0A, 5'h1E, 5'h00, 5'h0C, 5'h14, 5'h00, 5'h14};
        for (int i = 0; i < 7; i++)
        begin
            wr(COD_OFF_SYSCONF, 32'h1, 4'hF, COD_RESP_OKAY);
            wr(COD_OFF_PWRCTL, {28'h0, cfg[i]}, 4'hF, COD_RESP_OKAY);
            repeat (3) @(negedge aclk);
            chk(flags, exp[i]);
            chk(divided_clock_output, 1'b0);
            // Wake leaves idle and power-down, but stand-by must ignore it
            @(posedge aclk);
            wake_request <= 1'b1;
            @(posedge aclk);
            wake_request <= 1'b0;
            repeat (2) @(negedge aclk);
            if (i < 5)
                chk(flags[1:0], 2'h3);
            else
            begin
                chk(flags, exp[i]);
                do_reset();
                @(negedge aclk);
                chk(flags, 5'h0B);
            end
        end
    endtask : t_modes

    // Main sequence
    initial
    begin
        failures   = 0;
        n_compared = 0;
        aresetn    = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {wake_request, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_pin_div();
        t_pin_off();
        do_reset();
        t_lock();
        t_modes();
        end_sim();
    end
endmodule : tb
